// ---- inc/cmp2_map.svh ----
// register offsets, field positions and reset values of comparator two
// assumes a 9-bit byte address on the plain register port
`ifndef CMP2_MAP_SVH
`define CMP2_MAP_SVH
`define CMP2_PRI_ADDR 9'h11a
`define CMP2_SYNC_ADDR 9'h11b
`define CMP2_STAT_ADDR 9'h120
`define CMP2_MASK_ADDR 9'h121
`define CMP2_EN_BIT 7
`define CMP2_RES_BIT 6
`define CMP2_OE_BIT 5
`define CMP2_POL_BIT 4
`define CMP2_SP_BIT 3
`define CMP2_REF_BIT 2
`define CMP2_CH_HI 1
`define CMP2_CH_LO 0
`define CMP2_SYNC_BIT 0
`define CMP2_MIR1_BIT 7
`define CMP2_MIR2_BIT 6
`define CMP2_ST_MISM_BIT 0
`define CMP2_ST_SYNC_BIT 1
`define CMP2_CTRL_RST 7'h00
`define CMP2_SYNC_RST 1'h0
`define CMP2_MASK_RST 2'h0
`define CMP2_STAT_RST 2'h0
`define CMP2_RDATA_RST 8'h00
`endif

// ---- inc/cmp2_pkg.sv ----
// types shared by the comparator two control modules
// assumes cmp2_map.svh for every number
package cmp2_pkg;
  typedef struct packed {
    logic en;
    logic oe;
    logic pol;
    logic sp;
    logic r;
    logic [1:0] ch;
  } cmp2_ctrl_t;

  typedef struct packed {
    cmp2_ctrl_t ctrl;
    logic sync_en;
    logic last_read;
    logic [1:0] status;
    logic [1:0] mask;
    logic [7:0] rdata;
    logic [3:0] route;
    logic ref_dac;
    logic ref_pin;
    logic pin_oe;
    logic irq;
  } cmp2_top_st_t;

  typedef struct packed {
    logic tclk;
    logic sync_val;
    logic result;
    logic upd;
  } cmp2_lat_st_t;
endpackage : cmp2_pkg

// ---- inc/cmp2_res_if.sv ----
// result path signals between the register block and the result latch
// assumes both ends run on the instruction clock
`timescale 1ns/1ps
interface cmp2_res_if;
  logic raw;
  logic pol;
  logic en;
  logic sync_en;
  logic tclk;
  logic ce;
  logic result;
  logic pin_val;
  logic sync_evt;
  modport ctrl (output raw, pol, en, sync_en, tclk, ce,
                input result, pin_val, sync_evt);
  modport lat (input raw, pol, en, sync_en, tclk, ce,
               output result, pin_val, sync_evt);
endinterface : cmp2_res_if

// ---- verilog/cmp2_latch.sv ----
// result latch of comparator two with optional timer clock sync
// assumes the timer clock input is synchronous to the instruction clock
`timescale 1ns/1ps
`include "cmp2_map.svh"
module cmp2_latch (
  input wire logic clk,
  input wire logic rst_b,
  cmp2_res_if.lat res
);
  import cmp2_pkg::*;

  cmp2_lat_st_t s_q;
  cmp2_lat_st_t s_d;
  logic live;
  logic fall;

  always_comb begin
    live = res.en & (res.raw ^ res.pol);
    fall = s_q.tclk & ~res.tclk;
    s_d = s_q;
    s_d.tclk = res.tclk;
    s_d.upd = res.sync_en & fall;
    if (res.sync_en & fall) begin
      s_d.sync_val = live;
    end
    s_d.result = res.sync_en ? s_d.sync_val : live;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else if (res.ce) begin
      s_q <= s_d;
    end
  end

  // pin path stays unlatched unless sync mode holds it
  assign res.pin_val = res.sync_en ? s_q.sync_val : live;
  assign res.result = s_q.result;
  assign res.sync_evt = s_q.upd;

  a_latch_each_cycle: assert property (
    @(posedge clk) disable iff (!rst_b)
    (res.ce && !res.sync_en) |=> (res.result == $past(live)))
    else $error("result not latched from live compare");

  a_polarity_invert: assert property (
    @(posedge clk) disable iff (!rst_b)
    (res.ce && !res.sync_en && res.en && res.pol && res.raw)
    |=> !res.result)
    else $error("inverted polarity not applied");

  a_sync_hold_value: assert property (
    @(posedge clk) disable iff (!rst_b)
    (res.ce && res.sync_en && !(s_q.tclk && !res.tclk))
    |=> $stable(s_q.sync_val))
    else $error("synced result moved without timer falling edge");
endmodule : cmp2_latch

// ---- verilog/cmp2_ctrl.sv ----
// control and status registers of comparator two, with interrupt
// assumes the analog core returns raw high when noninverting > inverting
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`include "cmp2_map.svh"

// What this block does
// - The comparator works only while enable bit 7 is one.
// - Channel bits 1:0 route the inverting input to pin 4, 5, 6 or 7.
// - Reference bit 2 picks the DAC when one and the pin when zero.
// - The result reads back in read-only bit 6 of the primary register.
// - Outside sync mode the result is latched every cycle while the pin path is not.
// - Polarity bit 4 inverts the result, else high when plus beats minus.
// - Speed bit 3 picks normal speed when one, low power when zero.
// - The pin is driven only with oe, enable, direction zero, gate open.
// - The interrupt works the same with the pin output on or off.
// - With sync bit 0 set the output changes only on a timer fall.
// - Sync register bits 7 and 6 mirror the first and second results.
// - Bits 5 to 1 of the sync register always read zero.
// - Any reset restores reset values and leaves the comparator off.
module cmp2_ctrl #(
  parameter int ADDR_W = 9
) (
  input wire logic SYS_CLK_IN,
  input wire logic RST_B_IN,
  input wire logic CLK_EN_IN,
  input wire logic [ADDR_W-1:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic CMP_RAW_IN,
  input wire logic FIRST_RESULT_IN,
  input wire logic PORT_B_DIRECTION_IN,
  input wire logic PULSE_CONTROLLER_ENABLE_IN,
  input wire logic PULSE_CONTROLLER_OUTPUT_MODE_IN,
  input wire logic SLOPE_COMPENSATION_ENABLE_IN,
  input wire logic TIMER_CLOCK_INPUT_IN,
  output logic [7:0] RDATA_OUT,
  output logic COMPARATOR_ENABLE_OUT,
  output logic [3:0] INV_ROUTE_OUT,
  output logic REF_DAC_SEL_OUT,
  output logic REF_PIN_SEL_OUT,
  output logic SPEED_SELECT_OUT,
  output logic COMPARATOR_RESULT_OUT,
  output logic RESULT_PIN_OUT,
  output logic RESULT_PIN_OE_OUT,
  output logic IRQ_OUT
);
  import cmp2_pkg::*;

  if (ADDR_W < 9) begin : g_bad_addr_w
    $error("ADDR_W must hold the 9-bit register offsets");
  end

  logic [1:0] rs_q;
  logic rst_b;
  cmp2_top_st_t s_q;
  cmp2_top_st_t s_d;
  logic [8:0] a;
  logic wr_pri;
  logic wr_sync;
  logic wr_mask;
  logic rd_pri;
  logic rd_sync;
  logic rd_stat;
  logic rd_mask;
  logic mism;
  logic pin_ok;
  logic [1:0] ev;

  cmp2_res_if res ();

  cmp2_latch u_latch (
    .clk(SYS_CLK_IN),
    .rst_b(rst_b),
    .res(res.lat)
  );

  // reset release through two flops
  always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      rs_q <= 2'h0;
    end else begin
      rs_q <= {rs_q[0], 1'b1};
    end
  end
  assign rst_b = rs_q[1];

  assign res.raw = CMP_RAW_IN;
  assign res.pol = s_q.ctrl.pol;
  assign res.en = s_q.ctrl.en;
  assign res.sync_en = s_q.sync_en;
  assign res.tclk = TIMER_CLOCK_INPUT_IN;
  assign res.ce = CLK_EN_IN;

  always_comb begin
    a = ADDR_IN[8:0];
    wr_pri = WR_IN && (a == `CMP2_PRI_ADDR);
    wr_sync = WR_IN && (a == `CMP2_SYNC_ADDR);
    wr_mask = WR_IN && (a == `CMP2_MASK_ADDR);
    rd_pri = RD_IN && (a == `CMP2_PRI_ADDR);
    rd_sync = RD_IN && (a == `CMP2_SYNC_ADDR);
    rd_stat = RD_IN && (a == `CMP2_STAT_ADDR);
    rd_mask = RD_IN && (a == `CMP2_MASK_ADDR);
    if (ADDR_W > 9) begin
      if (ADDR_IN >> 9 != '0) begin
        wr_pri = 1'b0;
        wr_sync = 1'b0;
        wr_mask = 1'b0;
        rd_pri = 1'b0;
        rd_sync = 1'b0;
        rd_stat = 1'b0;
        rd_mask = 1'b0;
      end
    end
    mism = res.result != s_q.last_read;
    ev = 2'h0;
    ev[`CMP2_ST_MISM_BIT] = mism;
    ev[`CMP2_ST_SYNC_BIT] = res.sync_evt;

    s_d = s_q;
    s_d.rdata = 8'h00;
    if (wr_pri) begin
      // bit 6 is the result and cannot be written
      s_d.ctrl.en = WDATA_IN[`CMP2_EN_BIT];
      s_d.ctrl.oe = WDATA_IN[`CMP2_OE_BIT];
      s_d.ctrl.pol = WDATA_IN[`CMP2_POL_BIT];
      s_d.ctrl.sp = WDATA_IN[`CMP2_SP_BIT];
      s_d.ctrl.r = WDATA_IN[`CMP2_REF_BIT];
      s_d.ctrl.ch = WDATA_IN[`CMP2_CH_HI:`CMP2_CH_LO];
    end
    if (wr_sync) begin
      s_d.sync_en = WDATA_IN[`CMP2_SYNC_BIT];
    end
    if (wr_mask) begin
      s_d.mask = WDATA_IN[1:0];
    end
    if (rd_pri) begin
      s_d.rdata[`CMP2_EN_BIT] = s_q.ctrl.en;
      s_d.rdata[`CMP2_RES_BIT] = res.result;
      s_d.rdata[`CMP2_OE_BIT] = s_q.ctrl.oe;
      s_d.rdata[`CMP2_POL_BIT] = s_q.ctrl.pol;
      s_d.rdata[`CMP2_SP_BIT] = s_q.ctrl.sp;
      s_d.rdata[`CMP2_REF_BIT] = s_q.ctrl.r;
      s_d.rdata[`CMP2_CH_HI:`CMP2_CH_LO] = s_q.ctrl.ch;
      s_d.last_read = res.result;
    end
    if (rd_sync) begin
      // bits 5:1 stay zero
      s_d.rdata[`CMP2_MIR1_BIT] = FIRST_RESULT_IN;
      s_d.rdata[`CMP2_MIR2_BIT] = res.result;
      s_d.rdata[`CMP2_SYNC_BIT] = s_q.sync_en;
    end
    if (rd_stat) begin
      s_d.rdata[1:0] = s_q.status;
    end
    if (rd_mask) begin
      s_d.rdata[1:0] = s_q.mask;
    end
    // a status read clears the status, a same-cycle event still sets it
    s_d.status = (rd_stat ? 2'h0 : s_q.status) | ev;
    s_d.irq = |(s_d.status & s_d.mask);

    s_d.route = s_d.ctrl.en ? (4'h1 << s_d.ctrl.ch) : 4'h0;
    s_d.ref_dac = s_d.ctrl.en & s_d.ctrl.r;
    s_d.ref_pin = s_d.ctrl.en & ~s_d.ctrl.r;
    pin_ok = s_d.ctrl.oe && s_d.ctrl.en && !PORT_B_DIRECTION_IN &&
             (!PULSE_CONTROLLER_ENABLE_IN ||
              (!PULSE_CONTROLLER_OUTPUT_MODE_IN &&
               !SLOPE_COMPENSATION_ENABLE_IN));
    s_d.pin_oe = pin_ok;
  end

  always_ff @(posedge SYS_CLK_IN or negedge rst_b) begin
    if (!rst_b) begin
      s_q.ctrl <= `CMP2_CTRL_RST;
      s_q.sync_en <= `CMP2_SYNC_RST;
      s_q.last_read <= 1'b0;
      s_q.status <= `CMP2_STAT_RST;
      s_q.mask <= `CMP2_MASK_RST;
      s_q.rdata <= `CMP2_RDATA_RST;
      s_q.route <= 4'h0;
      s_q.ref_dac <= 1'b0;
      s_q.ref_pin <= 1'b0;
      s_q.pin_oe <= 1'b0;
      s_q.irq <= 1'b0;
    end else if (CLK_EN_IN) begin
      s_q <= s_d;
    end
  end

  assign RDATA_OUT = s_q.rdata;
  assign COMPARATOR_ENABLE_OUT = s_q.ctrl.en;
  assign INV_ROUTE_OUT = s_q.route;
  assign REF_DAC_SEL_OUT = s_q.ref_dac;
  assign REF_PIN_SEL_OUT = s_q.ref_pin;
  assign SPEED_SELECT_OUT = s_q.ctrl.sp;
  assign COMPARATOR_RESULT_OUT = res.result;
  // pin value is registered only in sync mode, by the latch
  assign RESULT_PIN_OUT = res.pin_val;
  assign RESULT_PIN_OE_OUT = s_q.pin_oe;
  assign IRQ_OUT = s_q.irq;

  a_disabled_quiet: assert property (
    @(posedge SYS_CLK_IN) disable iff (!rst_b)
    (CLK_EN_IN && !wr_pri && !s_q.ctrl.en && !s_q.sync_en)
    |=> (!COMPARATOR_RESULT_OUT && INV_ROUTE_OUT == 4'h0))
    else $error("disabled comparator still active");

  a_chan_route: assert property (
    @(posedge SYS_CLK_IN) disable iff (!rst_b)
    s_q.ctrl.en |-> (INV_ROUTE_OUT == (4'h1 << s_q.ctrl.ch)))
    else $error("inverting input route wrong");

  a_ref_select: assert property (
    @(posedge SYS_CLK_IN) disable iff (!rst_b)
    s_q.ctrl.en |-> (REF_DAC_SEL_OUT == s_q.ctrl.r &&
                     REF_PIN_SEL_OUT == !s_q.ctrl.r))
    else $error("reference select wrong");

  a_result_readback: assert property (
    @(posedge SYS_CLK_IN) disable iff (!rst_b)
    (CLK_EN_IN && rd_pri)
    |=> RDATA_OUT[`CMP2_RES_BIT] == $past(COMPARATOR_RESULT_OUT))
    else $error("result bit read back wrong");

  a_speed_write: assert property (
    @(posedge SYS_CLK_IN) disable iff (!rst_b)
    (CLK_EN_IN && wr_pri)
    |=> SPEED_SELECT_OUT == $past(WDATA_IN[`CMP2_SP_BIT]))
    else $error("speed select not taken from write");

  a_pin_gate: assert property (
    @(posedge SYS_CLK_IN) disable iff (!rst_b)
    (CLK_EN_IN && (PORT_B_DIRECTION_IN ||
     (PULSE_CONTROLLER_ENABLE_IN &&
      (SLOPE_COMPENSATION_ENABLE_IN || PULSE_CONTROLLER_OUTPUT_MODE_IN))))
    |=> !RESULT_PIN_OE_OUT)
    else $error("pin driven against its gate");

  a_irq_no_pin: assert property (
    @(posedge SYS_CLK_IN) disable iff (!rst_b)
    (CLK_EN_IN && mism) |=> s_q.status[`CMP2_ST_MISM_BIT])
    else $error("mismatch flag missed");

  a_mirror_read: assert property (
    @(posedge SYS_CLK_IN) disable iff (!rst_b)
    (CLK_EN_IN && rd_sync)
    |=> (RDATA_OUT[`CMP2_MIR1_BIT] == $past(FIRST_RESULT_IN) &&
         RDATA_OUT[`CMP2_MIR2_BIT] == $past(COMPARATOR_RESULT_OUT)))
    else $error("mirror bits wrong");

  a_unimpl_zero: assert property (
    @(posedge SYS_CLK_IN) disable iff (!rst_b)
    (CLK_EN_IN && rd_sync) |=> RDATA_OUT[5:1] == 5'h00)
    else $error("unimplemented bits not zero");

  a_reset_off: assert property (
    @(posedge SYS_CLK_IN)
    !rst_b |-> (!COMPARATOR_ENABLE_OUT && !RESULT_PIN_OE_OUT && !IRQ_OUT))
    else $error("comparator not off in reset");

  a_clear_on_read: assert property (
    @(posedge SYS_CLK_IN) disable iff (!rst_b)
    (CLK_EN_IN && rd_pri) |=> s_q.last_read == $past(res.result))
    else $error("primary read did not clear mismatch");

  a_ro_ignored: assert property (
    @(posedge SYS_CLK_IN) disable iff (!rst_b)
    (CLK_EN_IN && wr_sync) |=> s_q.ctrl == $past(s_q.ctrl))
    else $error("sync register write touched control bits");

  a_route_off: assert property (
    @(posedge SYS_CLK_IN) disable iff (!rst_b)
    !s_q.ctrl.en |-> (INV_ROUTE_OUT == 4'h0 && !REF_DAC_SEL_OUT &&
                      !REF_PIN_SEL_OUT))
    else $error("disabled comparator still routed");

  a_rdata_one_cycle: assert property (
    @(posedge SYS_CLK_IN) disable iff (!rst_b)
    (CLK_EN_IN && !RD_IN) |=> RDATA_OUT == 8'h00)
    else $error("read data held past its cycle");

  a_pin_needs_oe: assert property (
    @(posedge SYS_CLK_IN) disable iff (!rst_b)
    (CLK_EN_IN && !wr_pri && !(s_q.ctrl.en && s_q.ctrl.oe))
    |=> !RESULT_PIN_OE_OUT)
    else $error("pin driven without enable and output enable");

  a_sync_evt_flag: assert property (
    @(posedge SYS_CLK_IN) disable iff (!rst_b)
    (CLK_EN_IN && res.sync_evt) |=> s_q.status[`CMP2_ST_SYNC_BIT])
    else $error("synced update not flagged");

  a_stat_clear: assert property (
    @(posedge SYS_CLK_IN) disable iff (!rst_b)
    (CLK_EN_IN && rd_stat && !mism && !res.sync_evt)
    |=> s_q.status == 2'h0)
    else $error("status read did not clear");

  a_unmapped_write: assert property (
    @(posedge SYS_CLK_IN) disable iff (!rst_b)
    (CLK_EN_IN && WR_IN && !wr_pri && !wr_sync && !wr_mask)
    |=> (s_q.ctrl == $past(s_q.ctrl) &&
         s_q.sync_en == $past(s_q.sync_en)))
    else $error("unmapped write changed control bits");
endmodule : cmp2_ctrl

// ---- testbench/cmp2_ctrl_test.sv ----
// self-checking bench for the comparator two control block
// assumes cmp2_ctrl, its interface and cmp2_map.svh compile alongside
`timescale 1ns/1ps
`include "cmp2_map.svh"
module cmp2_ctrl_test;
  logic clk, rst_b, wr, rd, raw, c1, tclk;
  logic dir, pen, pmode, slope, ce;
  logic [8:0] addr;
  logic [7:0] wdata, rdata;
  logic en_o, rdac, rpin, spd, res, pin, pin_oe, irq;
  logic [3:0] route;
  logic [3:0] v;
  int fail_count, num_checks;

  cmp2_ctrl cmp2_ctrl_i (
    .SYS_CLK_IN(clk), .RST_B_IN(rst_b), .CLK_EN_IN(ce),
    .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd),
    .CMP_RAW_IN(raw), .FIRST_RESULT_IN(c1), .PORT_B_DIRECTION_IN(dir),
    .PULSE_CONTROLLER_ENABLE_IN(pen),
    .PULSE_CONTROLLER_OUTPUT_MODE_IN(pmode),
    .SLOPE_COMPENSATION_ENABLE_IN(slope), .TIMER_CLOCK_INPUT_IN(tclk),
    .RDATA_OUT(rdata), .COMPARATOR_ENABLE_OUT(en_o), .INV_ROUTE_OUT(route),
    .REF_DAC_SEL_OUT(rdac), .REF_PIN_SEL_OUT(rpin), .SPEED_SELECT_OUT(spd),
    .COMPARATOR_RESULT_OUT(res), .RESULT_PIN_OUT(pin),
    .RESULT_PIN_OE_OUT(pin_oe), .IRQ_OUT(irq));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask : chk

  task idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle

  task wr_reg(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // read data stand only in the cycle after the strobe
  task rd_chk(input logic [8:0] a, input logic [7:0] exp, input bit c);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    if (c) chk(rdata, exp);
  endtask : rd_chk

  // one timer clock high then low, then let the latch settle
  task tpulse;
    @(posedge clk) tclk <= 1'b1;
    idle(2);
    @(posedge clk) tclk <= 1'b0;
    idle(4);
  endtask : tpulse

  task results;
    $display("checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    results();
  end

  initial begin
    {rst_b, wr, rd, raw, c1, tclk, dir, pen, pmode, slope} = '0;
    addr = '0;
    wdata = '0;
    ce = 1'b1;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    idle(3);
    rd_chk(`CMP2_PRI_ADDR, 8'h00, 1);
    rd_chk(`CMP2_SYNC_ADDR, 8'h00, 1);
    chk(en_o, 1'b0);
    rd_chk(9'h100, 8'h00, 1);
    // every channel code with the DAC reference, analog selects set
    for (int ch = 0; ch < 4; ch++) begin
      wr_reg(`CMP2_PRI_ADDR, 8'h8c | 8'(ch));
      idle(1);
      chk({en_o, spd, rdac, rpin, route}, 8'he0 | (8'h1 << ch));
    end
    wr_reg(`CMP2_PRI_ADDR, 8'h88);
    idle(1);
    chk({en_o, spd, rdac, rpin, route}, 8'hd1);
    wr_reg(`CMP2_PRI_ADDR, 8'h0d);
    idle(1);
    chk({en_o, spd, rdac, rpin, route}, 8'h40);
    @(posedge clk) raw <= 1'b1;
    // bit 6 written high must be ignored
    for (int p = 0; p < 2; p++) begin
      wr_reg(`CMP2_PRI_ADDR, 8'hc0 | 8'(p << 4));
      idle(3);
      rd_chk(`CMP2_PRI_ADDR, p ? 8'h90 : 8'hc0, 1);
      chk({res, pin}, p ? 2'b00 : 2'b11);
    end
    wr_reg(`CMP2_PRI_ADDR, 8'h80);
    idle(3);
    @(posedge clk) raw <= 1'b0;
    #1;
    chk({pin, res}, 2'b01);
    idle(3);
    chk(res, 1'b0);
    wr_reg(`CMP2_PRI_ADDR, 8'ha0);
    for (int i = 0; i < 16; i++) begin
      v = 4'(i);
      @(posedge clk) {dir, pen, pmode, slope} <= v;
      idle(2);
      chk(pin_oe, !v[3] && (!v[2] || v[1:0] == 2'b00));
    end
    @(posedge clk) {dir, pen, pmode, slope} <= 4'h0;
    wr_reg(`CMP2_PRI_ADDR, 8'h20);
    idle(2);
    chk(pin_oe, 1'b0);
    @(posedge clk) raw <= 1'b1;
    c1 <= 1'b1;
    wr_reg(`CMP2_PRI_ADDR, 8'h80);
    idle(3);
    wr_reg(`CMP2_SYNC_ADDR, 8'hfe);
    rd_chk(`CMP2_SYNC_ADDR, 8'hc0, 1);
    wr_reg(`CMP2_SYNC_ADDR, 8'hff);
    tpulse();
    rd_chk(`CMP2_SYNC_ADDR, 8'hc1, 1);
    rd_chk(`CMP2_STAT_ADDR, 8'h03, 1);
    @(posedge clk) raw <= 1'b0;
    @(posedge clk) tclk <= 1'b1;
    idle(4);
    chk({res, pin}, 2'b11);
    @(posedge clk) tclk <= 1'b0;
    idle(4);
    chk({res, pin}, 2'b00);
    wr_reg(`CMP2_SYNC_ADDR, 8'h00);
    c1 <= 1'b0;
    // interrupt with the pin output left off
    wr_reg(`CMP2_MASK_ADDR, 8'h01);
    idle(3);
    rd_chk(`CMP2_PRI_ADDR, 8'h00, 0);
    rd_chk(`CMP2_STAT_ADDR, 8'h00, 0);
    idle(2);
    rd_chk(`CMP2_STAT_ADDR, 8'h00, 1);
    chk(irq, 1'b0);
    @(posedge clk) raw <= 1'b1;
    idle(4);
    chk(irq, 1'b1);
    rd_chk(`CMP2_STAT_ADDR, 8'h01, 1);
    wr_reg(`CMP2_MASK_ADDR, 8'h00);
    idle(2);
    chk(irq, 1'b0);
    rd_chk(`CMP2_MASK_ADDR, 8'h00, 1);
    wr_reg(`CMP2_MASK_ADDR, 8'h01);
    idle(2);
    chk(irq, 1'b1);
    rd_chk(`CMP2_PRI_ADDR, 8'hc0, 1);
    rd_chk(`CMP2_STAT_ADDR, 8'h00, 0);
    idle(2);
    chk(irq, 1'b0);
    // clock enable low freezes the registers and drops the strobe
    @(posedge clk) ce <= 1'b0;
    wr_reg(`CMP2_PRI_ADDR, 8'h08);
    @(posedge clk) ce <= 1'b1;
    #1;
    chk({en_o, spd}, 2'b10);
    rd_chk(`CMP2_PRI_ADDR, 8'hc0, 1);
    // second reset in mid-run
    wr_reg(`CMP2_PRI_ADDR, 8'hbf);
    @(posedge clk) rst_b <= 1'b0;
    idle(2);
    chk({en_o, irq, pin_oe, route}, 8'h00);
    @(posedge clk) rst_b <= 1'b1;
    idle(3);
    rd_chk(`CMP2_PRI_ADDR, 8'h00, 1);
    rd_chk(`CMP2_MASK_ADDR, 8'h00, 1);
    results();
  end
endmodule : cmp2_ctrl_test
